// file: sleep_reset_defs.svh
/*
  Constants of the sleep reset enable bank: register offsets, write masks,
  reset values, bit positions and bus response codes.
  Assumes inclusion by bare name from design files; holds definitions only.
*/
`ifndef SLEEP_RESET_DEFS_SVH
`define SLEEP_RESET_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define CHIP_ENABLE_OFS 8'h38
`define HOST_ENABLE_OFS 8'h3c
`define CTRL_ENABLE_OFS 8'h40

// ----------------------------------------------------------------------------
// Reset values and masks of the three registers
// ----------------------------------------------------------------------------
`define CHIP_ENABLE_RST 32'h00000000
`define HOST_ENABLE_RST 32'h00000000
`define CTRL_ENABLE_RST 32'h00000000
`define CHIP_ENABLE_WMASK 32'h00000001
`define HOST_ENABLE_WMASK 32'h00040003
`define CTRL_ENABLE_WMASK 32'he0700ff7

// ----------------------------------------------------------------------------
// Host register bit positions
// ----------------------------------------------------------------------------
`define HOST_RTC_BIT 18
`define HOST_UART_BIT 1

// ----------------------------------------------------------------------------
// Controller register bit positions
// ----------------------------------------------------------------------------
`define CTRL_TIMER2_BIT 31
`define CTRL_TIMER1_BIT 30
`define CTRL_BANK_BIT 29
`define CTRL_PULSE4_BIT 22
`define CTRL_PULSE3_BIT 21
`define CTRL_PULSE2_BIT 20
`define CTRL_TACHO2_BIT 11
`define CTRL_SMBUS_BIT 10
`define CTRL_WDOG_BIT 9
`define CTRL_CPU_BIT 8
`define CTRL_TRACE_BIT 7
`define CTRL_DMA_BIT 6
`define CTRL_PM_BIT 5
`define CTRL_PULSE1_BIT 4
`define CTRL_TACHO1_BIT 2
`define CTRL_INTR_BIT 0

// ----------------------------------------------------------------------------
// Bus response codes
// ----------------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: sleep_reset_pkg.sv
/*
  Types and shared functions of the sleep reset enable bank.
  Assumes sleep_reset_defs.svh is on the include path.
*/
`include "sleep_reset_defs.svh"

package sleep_reset_pkg;

  // Register selected by a bus address.
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_CHIP,
    SEL_HOST,
    SEL_CTRL
  } reg_sel_t;

  // Decodes a byte address to a register; the low two bits are ignored.
  function automatic reg_sel_t reg_decode(input logic [7:0] addr);
    logic [7:0] word;
    word = {addr[7:2], 2'h0};
    if (word == `CHIP_ENABLE_OFS) begin
      return SEL_CHIP;
    end else if (word == `HOST_ENABLE_OFS) begin
      return SEL_HOST;
    end else if (word == `CTRL_ENABLE_OFS) begin
      return SEL_CTRL;
    end
    return SEL_NONE;
  endfunction

  // Merges write data into a register under byte strobes and a writable mask.
  function automatic logic [31:0] merge_write(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] bytes;
    logic [31:0] keep;
    bytes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    keep = bytes & wmask;
    return (old & ~keep) | (data & keep);
  endfunction

endpackage

// file: axil_reg_port.sv
/*
  AXI4-Lite slave front end: takes write address and data in either order,
  issues a one-cycle write strobe, answers reads from a combinational lookup.
  Assumes the register side answers rd_data and rd_hit in the same cycle.
*/
`timescale 1ns/10ps
`include "sleep_reset_defs.svh"

module axil_reg_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_hit,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit
);

  typedef struct packed {
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } port_state_t;

  port_state_t q;
  port_state_t d;

  // ---------------------------------------------------------------------------
  // Handshake logic
  // ---------------------------------------------------------------------------
  // Ready flags are recomputed from the next state so they stay registered.
  always_comb begin
    d = q;
    wr_en = 1'b0;
    if (s_awvalid && q.awready) begin
      d.aw_held = 1'b1;
      d.awaddr = s_awaddr;
    end
    if (s_wvalid && q.wready) begin
      d.w_held = 1'b1;
      d.wdata = s_wdata;
      d.wstrb = s_wstrb;
    end
    if (s_bvalid && s_bready) begin
      d.bvalid = 1'b0;
    end
    // Both halves held: perform the write once and answer.
    if (q.aw_held && q.w_held && !q.bvalid) begin
      wr_en = 1'b1;
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    d.awready = !d.aw_held && !d.bvalid;
    d.wready = !d.w_held && !d.bvalid;
    if (s_rvalid && s_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = rd_hit ? rd_data : 32'h00000000;
      d.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    d.arready = !d.rvalid;
  end

  // Registers the state; reset leaves both channels idle and ready.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign wr_addr = q.awaddr;
  assign wr_data = q.wdata;
  assign wr_strb = q.wstrb;
  assign rd_addr = s_araddr;
  assign s_awready = q.awready;
  assign s_wready = q.wready;
  assign s_bvalid = q.bvalid;
  assign s_bresp = q.bresp;
  assign s_arready = q.arready;
  assign s_rvalid = q.rvalid;
  assign s_rdata = q.rdata;
  assign s_rresp = q.rresp;

endmodule // axil_reg_port

// file: sleep_reset_enable_bank.sv
/*
  Sleep reset enable bank: three software registers (the host and controller ones
  choose, per peripheral, whether entering sleep resets it) and the reset outputs.
  Assumes asleep inputs come from logic on aclk, and aresetn is the main
  domain reset.
  Reserved read/write bits (host bit 0, controller bit 1) are stored and
  read back but drive nothing; chip bit 1 always reads zero.
  A reset output follows asleep and its enable one cycle later.
*/
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "sleep_reset_defs.svh"

module sleep_reset_enable_bank (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic rtc_asleep,
  input wire logic uart_asleep,
  input wire logic second_short_timer_asleep,
  input wire logic first_short_timer_asleep,
  input wire logic misc_register_bank_asleep,
  input wire logic fourth_pulse_output_asleep,
  input wire logic third_pulse_output_asleep,
  input wire logic second_pulse_output_asleep,
  input wire logic first_pulse_output_asleep,
  input wire logic second_tachometer_asleep,
  input wire logic first_tachometer_asleep,
  input wire logic first_smbus_controller_asleep,
  input wire logic watchdog_unit_asleep,
  input wire logic processor_asleep,
  input wire logic trace_fifo_debug_port_asleep,
  input wire logic dma_asleep,
  input wire logic power_management_block_asleep,
  input wire logic interrupt_logic_asleep,
  output logic rtc_sleep_reset,
  output logic uart_sleep_reset,
  output logic second_short_timer_sleep_reset,
  output logic first_short_timer_sleep_reset,
  output logic misc_register_bank_sleep_reset,
  output logic fourth_pulse_output_sleep_reset,
  output logic third_pulse_output_sleep_reset,
  output logic second_pulse_output_sleep_reset,
  output logic first_pulse_output_sleep_reset,
  output logic second_tachometer_sleep_reset,
  output logic first_tachometer_sleep_reset,
  output logic first_smbus_controller_sleep_reset,
  output logic watchdog_unit_sleep_reset,
  output logic processor_sleep_reset,
  output logic trace_fifo_debug_port_sleep_reset,
  output logic dma_sleep_reset,
  output logic power_management_block_sleep_reset,
  output logic interrupt_logic_sleep_reset
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  // One flop per sleep reset output, so outputs come straight from registers.
  typedef struct packed {
    // Software-visible enable registers.
    logic [31:0] chip_en;
    logic [31:0] host_en;
    logic [31:0] ctrl_en;
    // Host-side reset outputs.
    logic rtc_rst;
    logic uart_rst;
    // Controller-side reset outputs.
    logic timer2_rst;
    logic timer1_rst;
    logic bank_rst;
    logic pulse4_rst;
    logic pulse3_rst;
    logic pulse2_rst;
    logic pulse1_rst;
    logic tacho2_rst;
    logic tacho1_rst;
    logic smbus_rst;
    logic wdog_rst;
    logic cpu_rst;
    logic trace_rst;
    logic dma_rst;
    logic pm_rst;
    logic intr_rst;
  } bank_state_t;

  // Main domain reset value: enables clear and every reset output releases.
  localparam bank_state_t RESET_STATE = '{
    chip_en: `CHIP_ENABLE_RST,
    host_en: `HOST_ENABLE_RST,
    ctrl_en: `CTRL_ENABLE_RST,
    default: 1'b0
  };

  // Current and next state of the whole bank.
  bank_state_t q;
  bank_state_t d;

  // Write side of the front end: one-cycle strobe, address and data.
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;

  // Read side: the lookup answers in the cycle the address is offered.
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;

  // ---------------------------------------------------------------------------
  // Bus front end
  // ---------------------------------------------------------------------------
  // Answers a write one cycle after both halves are held.
  axil_reg_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_hit(wr_hit),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  // ---------------------------------------------------------------------------
  // Register file and reset generation
  // ---------------------------------------------------------------------------
  // Writes land through the writable mask, so read-only bits
  // stay zero; a sleep reset follows the enable seen in the previous cycle.
  // Read data are masked too, so a read-only bit never reads as one.
  always_comb begin
    sleep_reset_pkg::reg_sel_t wsel;
    sleep_reset_pkg::reg_sel_t rsel;
    wsel = sleep_reset_pkg::reg_decode(wr_addr);
    rsel = sleep_reset_pkg::reg_decode(rd_addr);
    d = q;
    // An unmapped write is still answered, with an error code.
    wr_hit = (wsel != sleep_reset_pkg::SEL_NONE);
    if (wr_en) begin
      case (wsel)
        sleep_reset_pkg::SEL_CHIP: begin
          // Only bit 0 is writable; bit 1 reads zero.
          d.chip_en = sleep_reset_pkg::merge_write(q.chip_en, wr_data, wr_strb, `CHIP_ENABLE_WMASK);
        end
        sleep_reset_pkg::SEL_HOST: begin
          // Real time clock, first UART and one reserved bit.
          d.host_en = sleep_reset_pkg::merge_write(q.host_en, wr_data, wr_strb, `HOST_ENABLE_WMASK);
        end
        sleep_reset_pkg::SEL_CTRL: begin
          // Every controller enable plus one reserved bit.
          d.ctrl_en = sleep_reset_pkg::merge_write(q.ctrl_en, wr_data, wr_strb, `CTRL_ENABLE_WMASK);
        end
        default: begin
          // Unmapped: nothing changes.
          d = q;
        end
      endcase
    end
    // Read lookup; unmapped addresses answer with an error and zero data.
    rd_hit = (rsel != sleep_reset_pkg::SEL_NONE);
    case (rsel)
      sleep_reset_pkg::SEL_CHIP: begin
        rd_data = q.chip_en & `CHIP_ENABLE_WMASK;
      end
      sleep_reset_pkg::SEL_HOST: begin
        rd_data = q.host_en & `HOST_ENABLE_WMASK;
      end
      sleep_reset_pkg::SEL_CTRL: begin
        rd_data = q.ctrl_en & `CTRL_ENABLE_WMASK;
      end
      default: begin
        rd_data = 32'h00000000;
      end
    endcase

    // Each reset holds only while its block sleeps with the enable set.
    // Enables are not gated by asleep: software may change them at any time.
    // Host register: real time clock and first UART.
    d.rtc_rst = rtc_asleep && q.host_en[`HOST_RTC_BIT];
    d.uart_rst = uart_asleep && q.host_en[`HOST_UART_BIT];

    // Controller register: short timers and the miscellaneous bank.
    d.timer2_rst = second_short_timer_asleep && q.ctrl_en[`CTRL_TIMER2_BIT];
    d.timer1_rst = first_short_timer_asleep && q.ctrl_en[`CTRL_TIMER1_BIT];
    d.bank_rst = misc_register_bank_asleep && q.ctrl_en[`CTRL_BANK_BIT];

    // Controller register: pulse outputs and tachometer inputs.
    d.pulse4_rst = fourth_pulse_output_asleep && q.ctrl_en[`CTRL_PULSE4_BIT];
    d.pulse3_rst = third_pulse_output_asleep && q.ctrl_en[`CTRL_PULSE3_BIT];
    d.pulse2_rst = second_pulse_output_asleep && q.ctrl_en[`CTRL_PULSE2_BIT];
    d.pulse1_rst = first_pulse_output_asleep && q.ctrl_en[`CTRL_PULSE1_BIT];
    d.tacho2_rst = second_tachometer_asleep && q.ctrl_en[`CTRL_TACHO2_BIT];
    d.tacho1_rst = first_tachometer_asleep && q.ctrl_en[`CTRL_TACHO1_BIT];

    // Controller register: bus, watchdog, core, debug and system blocks.
    d.smbus_rst = first_smbus_controller_asleep && q.ctrl_en[`CTRL_SMBUS_BIT];
    d.wdog_rst = watchdog_unit_asleep && q.ctrl_en[`CTRL_WDOG_BIT];
    d.cpu_rst = processor_asleep && q.ctrl_en[`CTRL_CPU_BIT];
    d.trace_rst = trace_fifo_debug_port_asleep && q.ctrl_en[`CTRL_TRACE_BIT];
    d.dma_rst = dma_asleep && q.ctrl_en[`CTRL_DMA_BIT];
    d.pm_rst = power_management_block_asleep && q.ctrl_en[`CTRL_PM_BIT];
    d.intr_rst = interrupt_logic_asleep && q.ctrl_en[`CTRL_INTR_BIT];
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // Main domain reset returns every enable and output to its default.
  // Reset is synchronous, so it must be held across at least one edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------------
  // Output wiring
  // ---------------------------------------------------------------------------
  // All reset outputs are plain copies of their flops, so nothing
  // combinational can glitch a peripheral into reset.

  // Host peripherals.
  assign rtc_sleep_reset = q.rtc_rst;
  assign uart_sleep_reset = q.uart_rst;

  // Short timers and the miscellaneous bank.
  assign second_short_timer_sleep_reset = q.timer2_rst;
  assign first_short_timer_sleep_reset = q.timer1_rst;
  assign misc_register_bank_sleep_reset = q.bank_rst;

  // Pulse outputs.
  assign fourth_pulse_output_sleep_reset = q.pulse4_rst;
  assign third_pulse_output_sleep_reset = q.pulse3_rst;
  assign second_pulse_output_sleep_reset = q.pulse2_rst;
  assign first_pulse_output_sleep_reset = q.pulse1_rst;

  // Tachometers and the bus controller.
  assign second_tachometer_sleep_reset = q.tacho2_rst;
  assign first_tachometer_sleep_reset = q.tacho1_rst;
  assign first_smbus_controller_sleep_reset = q.smbus_rst;

  // Watchdog, core, debug and system blocks.
  assign watchdog_unit_sleep_reset = q.wdog_rst;
  assign processor_sleep_reset = q.cpu_rst;
  assign trace_fifo_debug_port_sleep_reset = q.trace_rst;
  assign dma_sleep_reset = q.dma_rst;
  assign power_management_block_sleep_reset = q.pm_rst;
  assign interrupt_logic_sleep_reset = q.intr_rst;

endmodule // sleep_reset_enable_bank

// file: periph_model.sv
/*
  Model of the peripherals that receive the sleep resets.
  Assumes sleep requests come from the bench on aclk; flags a reset seen awake.
*/
`timescale 1ns/10ps
module periph_model (
  input wire logic aclk,
  input wire logic [17:0] sleep_req,
  input wire logic [17:0] sleep_reset,
  output logic [17:0] asleep,
  output logic [17:0] bad_reset
);
  logic [17:0] was_asleep_q = '0;
  logic [17:0] asleep_q = '0;
  logic [17:0] bad_q = '0;
  // --------------------------------------------------------------------------
  // Sleep state and reset watch
  // --------------------------------------------------------------------------
  // Peripherals enter and leave sleep one cycle after a request.
  // Writes to a sleeping peripheral are not relied upon here.
  always @(posedge aclk) begin
    asleep_q <= sleep_req;
    was_asleep_q <= asleep_q;
    bad_q <= bad_q | (sleep_reset & ~asleep_q & ~was_asleep_q);
  end
  assign asleep = asleep_q;
  assign bad_reset = bad_q;
endmodule // periph_model

// file: bank_sva.sv
/*
  Checker of the sleep reset enable bank: bus handshakes and reset outputs.
  Assumes it is bound to the bank's top module, port names matching.
*/
`timescale 1ns/10ps
module bank_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic rtc_asleep,
  input wire logic rtc_sleep_reset,
  input wire logic uart_asleep,
  input wire logic uart_sleep_reset,
  input wire logic processor_asleep,
  input wire logic processor_sleep_reset
);
  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  // A reset edge clears both answers and the clock and processor reset outputs.
  reset_clears_a: assert property (@(posedge aclk)
    !aresetn |=> !s_bvalid && !s_rvalid && !rtc_sleep_reset && !processor_sleep_reset)
    else $error("outputs not cleared by reset");
  bresp_holds_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp)) else $error("write answer dropped");
  rdata_holds_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata)) else $error("read answer dropped");
  read_latency_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_arvalid && s_arready |=> s_rvalid) else $error("read answer late");
  write_latency_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_awvalid && s_awready && s_wvalid && s_wready |=> ##1 s_bvalid) else $error("write answer late");
  write_blocked_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_bvalid |-> !s_awready && !s_wready) else $error("write taken during answer");
  read_blocked_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_rvalid |-> !s_arready) else $error("read taken during answer");
  rtc_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !rtc_asleep |=> !rtc_sleep_reset) else $error("clock reset while awake");
  uart_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    uart_sleep_reset |-> $past(uart_asleep)) else $error("uart reset while awake");
  cpu_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    processor_sleep_reset |-> $past(processor_asleep)) else $error("processor reset while awake");
endmodule // bank_sva

bind sleep_reset_enable_bank bank_sva chk (.*);

// file: testbench.sv
/*
  Self-checking bench of the sleep reset enable bank over AXI4-Lite.
  Assumes the defs header on the include path and the peripheral model.
*/
`timescale 1ns/10ps
`include "sleep_reset_defs.svh"
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
  $display("BAD %0t got %h expected %h", $time, got, exp); end end
module testbench;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e; logic [1:0] r;} row_t;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0, s_rdata;
  logic [3:0] s_wstrb = 4'h0;
  logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, r;
  logic [31:0] q;
  logic [17:0] req = '0, asl, rv, bad;
  int fails = 0, samples_checked = 0, cyc = 0, lag = 0;
  int pos[18] = '{18, 1, 31, 30, 29, 22, 21, 20, 4, 11, 2, 10, 9, 8, 7, 6, 5, 0};
  // Writes, then the read-back expected of it.
  row_t rows[6] = '{
    '{8'h38, 32'hffffffff, 4'hf, 32'h00000001, `RESP_OKAY},
    '{8'h3c, 32'hffffffff, 4'hf, 32'h00040003, `RESP_OKAY},
    '{8'h3c, 32'h00000000, 4'h4, 32'h00000003, `RESP_OKAY},
    '{8'h40, 32'hffffffff, 4'hf, 32'he0700ff7, `RESP_OKAY},
    '{8'h40, 32'h00000000, 4'h9, 32'h00700f00, `RESP_OKAY},
    '{8'h44, 32'hffffffff, 4'hf, 32'h00000000, `RESP_SLVERR}};
  sleep_reset_enable_bank dut (.*,
    .rtc_asleep(asl[0]), .uart_asleep(asl[1]), .second_short_timer_asleep(asl[2]),
    .first_short_timer_asleep(asl[3]), .misc_register_bank_asleep(asl[4]), .fourth_pulse_output_asleep(asl[5]),
    .third_pulse_output_asleep(asl[6]), .second_pulse_output_asleep(asl[7]), .first_pulse_output_asleep(asl[8]),
    .second_tachometer_asleep(asl[9]), .first_tachometer_asleep(asl[10]), .first_smbus_controller_asleep(asl[11]),
    .watchdog_unit_asleep(asl[12]), .processor_asleep(asl[13]), .trace_fifo_debug_port_asleep(asl[14]),
    .dma_asleep(asl[15]), .power_management_block_asleep(asl[16]), .interrupt_logic_asleep(asl[17]),
    .rtc_sleep_reset(rv[0]), .uart_sleep_reset(rv[1]), .second_short_timer_sleep_reset(rv[2]),
    .first_short_timer_sleep_reset(rv[3]), .misc_register_bank_sleep_reset(rv[4]),
    .fourth_pulse_output_sleep_reset(rv[5]), .third_pulse_output_sleep_reset(rv[6]),
    .second_pulse_output_sleep_reset(rv[7]), .first_pulse_output_sleep_reset(rv[8]),
    .second_tachometer_sleep_reset(rv[9]), .first_tachometer_sleep_reset(rv[10]),
    .first_smbus_controller_sleep_reset(rv[11]), .watchdog_unit_sleep_reset(rv[12]),
    .processor_sleep_reset(rv[13]), .trace_fifo_debug_port_sleep_reset(rv[14]), .dma_sleep_reset(rv[15]),
    .power_management_block_sleep_reset(rv[16]), .interrupt_logic_sleep_reset(rv[17]));
  periph_model peer (.aclk(aclk), .sleep_req(req), .sleep_reset(rv), .asleep(asl), .bad_reset(bad));
  // --------------------------------------------------------------------------
  // Clock, timeout and closing report
  // --------------------------------------------------------------------------
  initial forever #20 aclk = ~aclk;
  // Cuts a hung run short well beyond the expected few hundred cycles.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      conclude();
    end
  end
  task automatic conclude();
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // Bus tasks: handshakes are judged at the falling edge, acted on at the rising edge
  // --------------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] resp);
    logic ta, tw;
    @(posedge aclk);
    s_awaddr <= a; s_wdata <= d; s_wstrb <= s;
    s_awvalid <= 1'b1; s_wvalid <= 1'b1; s_bready <= (lag == 0);
    do begin
      @(negedge aclk);
      ta = s_awvalid && s_awready;
      tw = s_wvalid && s_wready;
      @(posedge aclk);
      if (ta) s_awvalid <= 1'b0;
      if (tw) s_wvalid <= 1'b0;
    end while (s_awvalid && !ta || s_wvalid && !tw);
    repeat (lag) @(posedge aclk);
    s_bready <= 1'b1;
    do @(negedge aclk); while (s_bvalid !== 1'b1);
    resp = s_bresp;
    @(posedge aclk) s_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    s_araddr <= a; s_arvalid <= 1'b1; s_rready <= (lag == 0);
    do @(negedge aclk); while (s_arready !== 1'b1);
    @(posedge aclk) s_arvalid <= 1'b0;
    repeat (lag) @(posedge aclk);
    s_rready <= 1'b1;
    do @(negedge aclk); while (s_rvalid !== 1'b1);
    d = s_rdata;
    resp = s_rresp;
    @(posedge aclk) s_rready <= 1'b0;
  endtask
  task automatic settle(input logic [17:0] v);
    @(posedge aclk) req <= v;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask
  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].s, r);
      `CHK(r, rows[i].r)
      rd(rows[i].a, q, r);
      `CHK({q, r}, {rows[i].e, rows[i].r})
    end
    // Each enable bit resets only its own peripheral, and only while asleep.
    for (int i = 0; i < 18; i++) begin
      wr(8'h3c, i < 2 ? 32'h1 << pos[i] : 32'h0, 4'hf, r);
      wr(8'h40, i < 2 ? 32'h0 : 32'h1 << pos[i], 4'hf, r);
      settle('1);
      `CHK(rv, 18'h1 << i)
      settle('0);
      `CHK(rv, 18'h0)
    end
    // Answers accepted late must stand unchanged until taken.
    lag = 3;
    wr(8'h40, 32'h00000400, 4'hf, r);
    `CHK(r, `RESP_OKAY)
    rd(8'h40, q, r);
    `CHK(q, 32'h00000400)
    lag = 0;
    // A reset in mid-sleep clears every enable and releases every reset.
    wr(8'h3c, 32'hffffffff, 4'hf, r);
    wr(8'h40, 32'hffffffff, 4'hf, r);
    wr(8'h38, 32'hffffffff, 4'hf, r);
    settle('1);
    `CHK(rv, 18'h3ffff)
    @(posedge aclk) aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK(rv, 18'h0)
    foreach (rows[i]) begin
      rd(rows[i].a, q, r);
      `CHK(q, 32'h0)
    end
    settle('0);
    `CHK(bad, 18'h0)
    conclude();
  end
endmodule // testbench
